// ### clock_synth_config_decode.sv
`timescale 1ns/1ps

// Overview of operation
// - Mode pins pick one of four modal sets
// - Modifier shifts ratio right by select plus one
// - Modifier applies only with pin high, function 011
// - Aux output source from two-bit select
// - Auto ratio modifier follows its enable bit, or the pin under code 101
// - Hybrid mode uses ratio picked by lock index
// - Static mode uses ratio of active set
// - Source bit picks static or dynamic ratio
// - Four 32-bit user ratios are stored
// - Clock skip keeps lock; input below 80 kHz
// - Lock indicator push-pull or open-drain by config
// - Lock config ignored when aux carries clock
// - Reference divider: 00 by 4, 01 by 2, 10 by 1
// - Unlock bit 0 holds clock outputs low unlocked
// - Hybrid ratio format 20.12 or 12.20 by bit
// - Static mode ratio always read as 12.20
// - Aux override function forces PLL clock source
// - Loop bandwidth 1 Hz doubling to 128 Hz
// - Codes 000-010 disable outputs while pin high
// - Code 011 pin high enables manual modifier
// - Code 110 pin overrides source unless auto switching
// - Code 111 pin high forces aux PLL clock
module clock_synth_config_decode
	import clock_synth_pkg::*;
(
	// Clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// AXI4-Lite register slave
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// Mode pins
	input  wire logic [1:0]          mode_pins,
	input  wire logic                special_function_pin,
	// PLL and clock inputs
	input  wire logic                pll_locked,
	input  wire logic                timing_reference,
	input  wire logic                frequency_reference,
	input  wire logic                pll_clock,
	input  wire logic                auto_switch_request,
	input  wire logic                auto_select_dynamic,
	input  wire logic [RATIO_W-1:0]  dynamic_ratio,
	// Clock outputs
	output logic                     clk_out,
	output logic                     clk_out_oe,
	output logic                     aux_out,
	output logic                     aux_out_oe,
	output logic                     divided_timing_reference,
	// Decoded configuration
	output logic [RATIO_W-1:0]       effective_ratio,
	output logic [RATIO_W-1:0]       fractional_value,
	output logic                     ratio_high_accuracy,
	output logic                     hybrid_mode,
	output logic                     auto_modifier_active,
	output logic                     clock_skip_active,
	output logic [7:0]               min_loop_bandwidth_hz,
	output logic                     divider_reserved
);

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	// Stored image and active copy
	logic [RATIO_W-1:0] ratio_store  [RATIO_COUNT];
	modal_t             modal_store  [RATIO_COUNT];
	global_t            global_store;
	logic [RATIO_W-1:0] ratio_active [RATIO_COUNT];
	modal_t             modal_active [RATIO_COUNT];
	global_t            global_active;
	logic               load_pending;
	logic               load_now;

	// Bus state
	wr_state_t          wr_state;
	wr_state_t          next_wr_state;
	rd_state_t          rd_state;
	logic [7:0]         wr_addr_q;
	logic [31:0]        wr_data_q;
	logic [3:0]         wr_strb_q;
	logic               aw_hs;
	logic               w_hs;
	logic               wr_fire;
	logic [7:0]         wr_addr;
	logic [31:0]        wr_data;
	logic [3:0]         wr_strb;
	logic [7:0]         wr_aligned;
	logic [7:0]         rd_aligned;
	logic               ctrl_reload;
	logic               wr_mapped;

	// Decode
	modal_t             active_set;
	logic               manual_on;
	logic               auto_switch_on;
	logic               dynamic_selected;
	logic [1:0]         ratio_index;
	logic [RATIO_W-1:0] raw_ratio;
	logic [2:0]         shift_amount;
	logic [RATIO_W-1:0] next_effective;
	aux_source_t        aux_source;
	aux_source_t        aux_source_active;
	logic               clk_disable;
	logic               aux_disable;
	logic               outputs_gated;
	logic               next_aux_out;
	logic               next_aux_oe;
	logic               ref_prev;
	logic               ref_edge;
	logic               div_count;
	logic               next_divided;
	status_t            status_word;

	assign aw_hs   = s_axi_awvalid && s_axi_awready;
	assign w_hs    = s_axi_wvalid && s_axi_wready;
	assign wr_addr = aw_hs ? s_axi_awaddr : wr_addr_q;
	assign wr_data = w_hs ? s_axi_wdata : wr_data_q;
	assign wr_strb = w_hs ? s_axi_wstrb : wr_strb_q;
	assign wr_fire = (wr_state != WR_RESP) && (next_wr_state == WR_RESP);
	assign wr_aligned  = {wr_addr[7:2], 2'b00};
	assign rd_aligned  = {s_axi_araddr[7:2], 2'b00};
	assign wr_mapped   = wr_aligned <= FRACTION_OFFSET;
	assign ctrl_reload = wr_fire && (wr_aligned == CONTROL_OFFSET) && wr_strb[0] && wr_data[CONTROL_RELOAD_BIT];
	assign load_now    = load_pending || ctrl_reload;

	always_comb begin
		next_wr_state = wr_state;
		case (wr_state)
			WR_IDLE: begin
				if (aw_hs && w_hs) begin
					next_wr_state = WR_RESP;
				end else if (aw_hs) begin
					next_wr_state = WR_ADDR;
				end else if (w_hs) begin
					next_wr_state = WR_DATA;
				end
			end
			WR_ADDR: begin
				if (w_hs) begin
					next_wr_state = WR_RESP;
				end
			end
			WR_DATA: begin
				if (aw_hs) begin
					next_wr_state = WR_RESP;
				end
			end
			WR_RESP: begin
				if (s_axi_bready) begin
					next_wr_state = WR_IDLE;
				end
			end
			default: next_wr_state = WR_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state      <= WR_IDLE;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			wr_addr_q     <= 8'h00;
			wr_data_q     <= 32'h0000_0000;
			wr_strb_q     <= 4'h0;
		end else begin
			wr_state      <= next_wr_state;
			s_axi_awready <= (next_wr_state == WR_IDLE) || (next_wr_state == WR_DATA);
			s_axi_wready  <= (next_wr_state == WR_IDLE) || (next_wr_state == WR_ADDR);
			s_axi_bvalid  <= next_wr_state == WR_RESP;
			if (aw_hs) begin
				wr_addr_q <= s_axi_awaddr;
			end
			if (w_hs) begin
				wr_data_q <= s_axi_wdata;
				wr_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Stored image; writes change behaviour only after a reload
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < RATIO_COUNT; i++) begin
				ratio_store[i] <= RATIO_RESET;
				modal_store[i] <= MODAL_RESET;
			end
			global_store <= GLOBAL_RESET;
		end else if (wr_fire) begin
			if (wr_aligned < MODAL_BASE_OFFSET) begin
				ratio_store[wr_aligned[3:2]] <= merge_bytes(ratio_store[wr_aligned[3:2]], wr_data, wr_strb);
			end else if (wr_aligned < GLOBAL_OFFSET) begin
				modal_store[wr_aligned[3:2]] <= modal_t'(8'(merge_bytes({24'h00_0000, modal_store[wr_aligned[3:2]]},
					wr_data, wr_strb)));
			end else if (wr_aligned == GLOBAL_OFFSET) begin
				global_store <= global_t'(12'(merge_bytes({20'h0_0000, global_store}, wr_data, wr_strb)));
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			load_pending <= 1'b1;
			for (int i = 0; i < RATIO_COUNT; i++) begin
				ratio_active[i] <= RATIO_RESET;
				modal_active[i] <= MODAL_RESET;
			end
			global_active <= GLOBAL_RESET;
		end else begin
			load_pending <= 1'b0;
			if (load_now) begin
				for (int i = 0; i < RATIO_COUNT; i++) begin
					ratio_active[i] <= ratio_store[i];
					modal_active[i] <= modal_store[i];
				end
				global_active <= global_store;
			end
		end
	end

	assign status_word = '{divider_reserved: divider_reserved, auto_modifier_active: auto_modifier_active,
		manual_modifier_active: manual_on, hybrid_mode: hybrid_mode, active_mode: mode_pins, pll_locked: pll_locked};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state      <= RD_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			case (rd_state)
				RD_IDLE: begin
					s_axi_arready <= 1'b1;
					if (s_axi_arvalid && s_axi_arready) begin
						rd_state      <= RD_DATA;
						s_axi_arready <= 1'b0;
						s_axi_rvalid  <= 1'b1;
						s_axi_rresp   <= RESP_OKAY;
						s_axi_rdata   <= 32'h0000_0000;
						if (rd_aligned < MODAL_BASE_OFFSET) begin
							s_axi_rdata <= ratio_store[rd_aligned[3:2]];
						end else if (rd_aligned < GLOBAL_OFFSET) begin
							s_axi_rdata <= {24'h00_0000, modal_store[rd_aligned[3:2]]};
						end else if (rd_aligned == GLOBAL_OFFSET) begin
							s_axi_rdata <= {20'h0_0000, global_store};
						end else if (rd_aligned == STATUS_OFFSET) begin
							s_axi_rdata <= {25'h000_0000, status_word};
						end else if (rd_aligned == FRACTION_OFFSET) begin
							s_axi_rdata <= fractional_value;
						end else if (rd_aligned != CONTROL_OFFSET) begin
							s_axi_rresp <= RESP_SLVERR;
						end
					end
				end
				RD_DATA: begin
					if (s_axi_rready) begin
						rd_state      <= RD_IDLE;
						s_axi_rvalid  <= 1'b0;
						s_axi_arready <= 1'b1;
					end
				end
				default: rd_state <= RD_IDLE;
			endcase
		end
	end

	// Ratio and source decode
	assign active_set     = modal_active[mode_pins];
	assign manual_on      = special_function_pin && (global_active.special_pin_function == FN_MANUAL_MOD);
	assign auto_switch_on = auto_switch_request &&
		!(special_function_pin && (global_active.special_pin_function == FN_AUTO_SW_OFF));

	always_comb begin
		if (auto_switch_on) begin
			dynamic_selected = auto_select_dynamic;
		end else if (global_active.special_pin_function == FN_SOURCE_SELECT) begin
			dynamic_selected = special_function_pin;
		end else begin
			dynamic_selected = active_set.fractional_source_bit;
		end
	end

	assign ratio_index    = dynamic_selected ? active_set.lock_ratio_index : mode_pins;
	assign raw_ratio      = ratio_active[ratio_index];
	assign shift_amount   = {1'b0, active_set.ratio_shift_select} + 3'h1;
	assign next_effective = manual_on ? (raw_ratio >> shift_amount) : raw_ratio;

	// Output routing
	assign aux_source = (special_function_pin && (global_active.special_pin_function == FN_AUX_OVERRIDE)) ?
		AUX_PLL_CLOCK : aux_source_t'(active_set.aux_source_select);
	assign clk_disable = special_function_pin && ((global_active.special_pin_function == FN_DISABLE_CLK) ||
		(global_active.special_pin_function == FN_DISABLE_BOTH));
	assign aux_disable = special_function_pin && ((global_active.special_pin_function == FN_DISABLE_AUX) ||
		(global_active.special_pin_function == FN_DISABLE_BOTH));
	assign outputs_gated = !global_active.unlock_output_bit && !pll_locked;

	always_comb begin
		next_aux_out = 1'b0;
		next_aux_oe  = !aux_disable;
		case (aux_source)
			AUX_TIMING_REF: next_aux_out = divided_timing_reference;
			AUX_FREQ_REF:   next_aux_out = frequency_reference;
			AUX_PLL_CLOCK:  next_aux_out = pll_clock && !outputs_gated;
			AUX_LOCK_STATUS: begin
				if (!global_active.lock_indicator_config) begin
					next_aux_out = !pll_locked;
				end else begin
					next_aux_out = 1'b0;
					next_aux_oe  = !aux_disable && !pll_locked;
				end
			end
			default: next_aux_out = 1'b0;
		endcase
	end

	// Timing reference divider
	assign ref_edge = timing_reference && !ref_prev;

	always_comb begin
		next_divided = divided_timing_reference;
		case (global_active.reference_divider)
			DIV_BY1: next_divided = timing_reference;
			DIV_BY2: next_divided = ref_edge ? !divided_timing_reference : divided_timing_reference;
			DIV_BY4: next_divided = (ref_edge && div_count) ? !divided_timing_reference : divided_timing_reference;
			default: next_divided = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_prev                 <= 1'b0;
			div_count                <= 1'b0;
			divided_timing_reference <= 1'b0;
		end else begin
			ref_prev                 <= timing_reference;
			div_count                <= ref_edge ? !div_count : div_count;
			divided_timing_reference <= next_divided;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_out               <= 1'b0;
			clk_out_oe            <= 1'b0;
			aux_out               <= 1'b0;
			aux_out_oe            <= 1'b0;
			aux_source_active     <= AUX_TIMING_REF;
			effective_ratio       <= RATIO_RESET;
			fractional_value      <= RATIO_RESET;
			ratio_high_accuracy   <= 1'b1;
			hybrid_mode           <= 1'b0;
			auto_modifier_active  <= 1'b0;
			clock_skip_active     <= 1'b0;
			min_loop_bandwidth_hz <= BANDWIDTH_BASE_HZ;
			divider_reserved      <= 1'b0;
		end else begin
			clk_out               <= pll_clock && !outputs_gated;
			clk_out_oe            <= !clk_disable;
			aux_out               <= next_aux_out;
			aux_out_oe            <= next_aux_oe;
			aux_source_active     <= aux_source;
			effective_ratio       <= next_effective;
			fractional_value      <= dynamic_selected ? dynamic_ratio : next_effective;
			ratio_high_accuracy   <= !dynamic_selected || global_active.low_frequency_format_bit;
			hybrid_mode           <= dynamic_selected;
			auto_modifier_active  <= (global_active.special_pin_function == FN_AUTO_MOD) ?
				special_function_pin : active_set.auto_ratio_modifier_enable;
			clock_skip_active     <= global_active.clock_skip_enable;
			min_loop_bandwidth_hz <= BANDWIDTH_BASE_HZ << global_active.min_loop_bandwidth;
			divider_reserved      <= global_active.reference_divider == DIV_RESERVED;
		end
	end

	ratio_shift_a: assert property (manual_on |=> effective_ratio == ($past(raw_ratio) >> $past(shift_amount)))
		else $error("shifted ratio wrong");
	no_modifier_a: assert property (!manual_on |=> effective_ratio == $past(raw_ratio))
		else $error("ratio modified without enable");
	static_index_a: assert property ((!dynamic_selected && !manual_on)
		|=> effective_ratio == $past(ratio_active[mode_pins]))
		else $error("static ratio index not mode");
	frac_source_a: assert property (dynamic_selected |=> fractional_value == $past(dynamic_ratio))
		else $error("dynamic ratio not used");
	lock_push_a: assert property ((aux_source == AUX_LOCK_STATUS && !global_active.lock_indicator_config && !aux_disable)
		|=> aux_out == !$past(pll_locked) && aux_out_oe)
		else $error("push-pull lock indicator wrong");
	lock_drain_a: assert property ((aux_source == AUX_LOCK_STATUS && global_active.lock_indicator_config)
		|=> !aux_out && (aux_out_oe == ($past(!aux_disable) && !$past(pll_locked))))
		else $error("open-drain lock indicator wrong");
	clock_gate_a: assert property ((!global_active.unlock_output_bit && !pll_locked) |=> !clk_out)
		else $error("clock not held low on unlock");
	aux_override_a: assert property ((special_function_pin && global_active.special_pin_function == FN_AUX_OVERRIDE)
		|=> aux_source_active == AUX_PLL_CLOCK)
		else $error("aux override ignored");
	format_static_a: assert property (!dynamic_selected |=> ratio_high_accuracy)
		else $error("static ratio not 12.20");
	divide_one_a: assert property (global_active.reference_divider == DIV_BY1
		|=> divided_timing_reference == $past(timing_reference))
		else $error("divide by one wrong");
	config_hold_a: assert property (!load_now |=> $stable(global_active) && $stable(ratio_active[0]))
		else $error("active configuration changed");
	bandwidth_a: assert property (##1 min_loop_bandwidth_hz == (BANDWIDTH_BASE_HZ << $past(global_active.min_loop_bandwidth)))
		else $error("loop bandwidth code wrong");

endmodule : clock_synth_config_decode

// ### clock_synth_pkg.sv
package clock_synth_pkg;

	// Register byte offsets, one aligned 32-bit word each
	localparam logic [7:0]  RATIO_BASE_OFFSET  = 8'h00;
	localparam logic [7:0]  MODAL_BASE_OFFSET  = 8'h10;
	localparam logic [7:0]  GLOBAL_OFFSET      = 8'h20;
	localparam logic [7:0]  CONTROL_OFFSET     = 8'h24;
	localparam logic [7:0]  STATUS_OFFSET      = 8'h28;
	localparam logic [7:0]  FRACTION_OFFSET    = 8'h2C;
	localparam int unsigned CONTROL_RELOAD_BIT = 0;

	localparam int unsigned RATIO_COUNT = 4;
	localparam int unsigned RATIO_W     = 32;

	typedef struct packed {
		logic       fractional_source_bit;
		logic [1:0] lock_ratio_index;
		logic       auto_ratio_modifier_enable;
		logic [1:0] aux_source_select;
		logic [1:0] ratio_shift_select;
	} modal_t;

	typedef struct packed {
		logic [2:0] min_loop_bandwidth;
		logic [2:0] special_pin_function;
		logic       low_frequency_format_bit;
		logic       unlock_output_bit;
		logic [1:0] reference_divider;
		logic       lock_indicator_config;
		logic       clock_skip_enable;
	} global_t;

	typedef struct packed {
		logic       divider_reserved;
		logic       auto_modifier_active;
		logic       manual_modifier_active;
		logic       hybrid_mode;
		logic [1:0] active_mode;
		logic       pll_locked;
	} status_t;

	localparam modal_t      MODAL_RESET  = 8'h00;
	localparam global_t     GLOBAL_RESET = 12'h000;
	localparam logic [31:0] RATIO_RESET  = 32'h0000_0000;

	typedef enum logic [1:0] {
		AUX_TIMING_REF  = 2'h0,
		AUX_FREQ_REF    = 2'h1,
		AUX_PLL_CLOCK   = 2'h2,
		AUX_LOCK_STATUS = 2'h3
	} aux_source_t;

	localparam logic [2:0] FN_DISABLE_CLK   = 3'h0;
	localparam logic [2:0] FN_DISABLE_AUX   = 3'h1;
	localparam logic [2:0] FN_DISABLE_BOTH  = 3'h2;
	localparam logic [2:0] FN_MANUAL_MOD    = 3'h3;
	localparam logic [2:0] FN_AUTO_SW_OFF   = 3'h4;
	localparam logic [2:0] FN_AUTO_MOD      = 3'h5;
	localparam logic [2:0] FN_SOURCE_SELECT = 3'h6;
	localparam logic [2:0] FN_AUX_OVERRIDE  = 3'h7;

	localparam logic [1:0] DIV_BY4      = 2'h0;
	localparam logic [1:0] DIV_BY2      = 2'h1;
	localparam logic [1:0] DIV_BY1      = 2'h2;
	localparam logic [1:0] DIV_RESERVED = 2'h3;

	localparam logic [7:0] BANDWIDTH_BASE_HZ = 8'h01;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_ADDR = 2'b01,
		WR_RESP = 2'b11,
		WR_DATA = 2'b10
	} wr_state_t;

	typedef enum logic {
		RD_IDLE = 1'b0,
		RD_DATA = 1'b1
	} rd_state_t;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : clock_synth_pkg

// ### clock_synth_board.sv
`timescale 1ns/1ps
module clock_synth_board (
	// Bench clock and the block's aux drive
	input  wire logic  aclk,
	input  wire logic  aux_out,
	input  wire logic  aux_out_oe,
	// Clocks toward the block and the resolved pin toward the bench
	output wire logic [2:0] clocks,
	output wire logic  aux_pin
);
	logic [2:0] count = 3'h0;
	// Gap-free clocks that move off the sampling edge
	always @(negedge aclk) count <= count + 3'h1;
	assign clocks = count;
	// Released pin rests at the pull-up level
	assign aux_pin = aux_out_oe ? aux_out : 1'b1;
endmodule : clock_synth_board

// ### clock_synth_config_decode_tb.sv
`timescale 1ns/1ps
module clock_synth_config_decode_tb;
	import clock_synth_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
	logic        rready = 1'b0, pin = 1'b0, locked = 1'b1, hi, asw = 1'b0, asel = 1'b0, dtr, am, skip;
	logic        awready, wready, bvalid, arready, rvalid, clk_out, clk_oe, aux_out, aux_oe, aux_pin, ha, hyb, dres;
	logic [1:0]  mode = 2'h0, bresp, rresp, r;
	logic [2:0]  clks;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, bw;
	logic [31:0] wdata = 32'h0000_0000, dyn = 32'hcafe_0001, rdata, eff, frac, d;
	logic [31:0] ratio [4] = '{32'h1234_5678, 32'h2000_0000, 32'h0013_a92a, 32'h8765_4320};
	int          n_mismatch = 0, checks = 0, cyc = 0, n;
	clock_synth_config_decode u_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .mode_pins(mode), .special_function_pin(pin), .pll_locked(locked),
		.timing_reference(clks[0]), .pll_clock(clks[1]), .frequency_reference(clks[2]), .auto_switch_request(asw),
		.auto_select_dynamic(asel), .dynamic_ratio(dyn), .clk_out(clk_out), .clk_out_oe(clk_oe), .aux_out(aux_out),
		.aux_out_oe(aux_oe), .divided_timing_reference(dtr), .effective_ratio(eff), .fractional_value(frac),
		.ratio_high_accuracy(ha), .hybrid_mode(hyb), .auto_modifier_active(am), .clock_skip_active(skip),
		.min_loop_bandwidth_hz(bw), .divider_reserved(dres));
	clock_synth_board u_board (.aclk(aclk), .aux_out(aux_out), .aux_out_oe(aux_oe), .clocks(clks), .aux_pin(aux_pin));
	always #25 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
		do begin
			@(posedge aclk);
			awvalid <= awvalid & ~awready;
			wvalid <= wvalid & ~wready;
		end while ((awvalid & ~awready) | (wvalid & ~wready));
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
		cmp(32'(bresp), 32'(RESP_OKAY));
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		{araddr, arvalid, rready} <= {a, 2'h3};
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b0;
		{r, d} = {rresp, rdata};
	endtask : rd
	task automatic cfg(input logic [7:0] a, input logic [31:0] v);
		wr(a, v);
		wr(CONTROL_OFFSET, 32'h0000_0001); // Stored image becomes active
		repeat (3) @(posedge aclk);
	endtask : cfg
	task automatic drv(input logic [1:0] m, input logic p, input logic l);
		@(posedge aclk);
		{mode, pin, locked} <= {m, p, l};
		repeat (3) @(posedge aclk);
	endtask : drv
	task automatic count_toggles(input logic use_aux);
		logic p;
		p = use_aux ? aux_pin : dtr;
		n = 0;
		repeat (16) begin
			@(posedge aclk);
			n += int'((use_aux ? aux_pin : dtr) != p);
			p = use_aux ? aux_pin : dtr;
		end
	endtask : count_toggles
	task automatic t_regs();
		for (int i = 0; i < 4; i++)
			wr(RATIO_BASE_OFFSET + 8'(4 * i), ratio[i]);
		cmp(eff, 32'h0000_0000);
		rd(RATIO_BASE_OFFSET + 8'h08);
		cmp(d, ratio[2]);
		rd(8'h30);
		cmp(32'(r), 32'(RESP_SLVERR));
	endtask : t_regs
	task automatic t_static();
		cfg(GLOBAL_OFFSET, 32'h0000_00c0);
		for (int m = 0; m < 4; m++) begin
			drv(2'(m), 1'b0, 1'b1);
			cmp(eff, ratio[m]);
		end
		cmp(32'(am), 32'h0);
		for (int s = 0; s < 4; s++) begin
			cfg(MODAL_BASE_OFFSET, 32'(s));
			drv(2'h0, 1'b1, 1'b1);
			cmp(eff, ratio[0] >> (s + 1));
		end
	endtask : t_static
	task automatic t_hybrid();
		cfg(MODAL_BASE_OFFSET + 8'h04, 32'h0000_00f0);
		drv(2'h1, 1'b0, 1'b1);
		cmp(eff, ratio[3]);
		cmp(frac, dyn);
		cmp(32'({hyb, ha}), 32'h2);
		cmp(32'(am), 32'h1);
		cfg(GLOBAL_OFFSET, 32'h0000_01a0);
		drv(2'h1, 1'b0, 1'b1);
		cmp(frac, ratio[1]);
		cmp(32'({hyb, ha}), 32'h1);
		drv(2'h1, 1'b1, 1'b1);
		cmp(32'({hyb, ha}), 32'h3);
		{asw, asel} <= 2'b10;
		drv(2'h1, 1'b1, 1'b1);
		cmp(32'({hyb, ha}), 32'h1);
		cfg(GLOBAL_OFFSET, 32'h0000_0100);
		drv(2'h1, 1'b1, 1'b1);
		cmp(32'(hyb), 32'h1);
		drv(2'h1, 1'b0, 1'b1);
		cmp(32'(hyb), 32'h0);
		asw <= 1'b0;
	endtask : t_hybrid
	task automatic t_aux();
		cfg(MODAL_BASE_OFFSET + 8'h08, 32'h0000_000c);
		for (int c = 0; c < 2; c++) begin
			cfg(GLOBAL_OFFSET, 32'(2 * c));
			for (int l = 0; l < 2; l++) begin
				drv(2'h2, 1'b0, 1'(l));
				cmp(32'({aux_oe, aux_pin}), 32'(c ? 2 - l : 3 - l));
			end
		end
		cfg(GLOBAL_OFFSET, 32'h0000_01ca);
		drv(2'h2, 1'b1, 1'b1);
		cmp(32'(aux_oe), 32'h1);
		count_toggles(1'b1);
		cmp(32'(n), 32'h8);
		for (int s = 0; s < 2; s++) begin
			cfg(MODAL_BASE_OFFSET + 8'h08, 32'(4 * s));
			drv(2'h2, 1'b0, 1'b1);
			count_toggles(1'b1);
			cmp(32'(n), 32'(16 >> (2 * s)));
		end
	endtask : t_aux
	task automatic t_outputs();
		for (int f = 0; f < 3; f++) begin
			cfg(GLOBAL_OFFSET, 32'h0000_0010 | 32'(f << 6));
			drv(2'h0, 1'b1, 1'b1);
			cmp(32'({clk_oe, aux_oe}), 32'({f == 1, f == 0}));
		end
		for (int u = 0; u < 2; u++) begin
			cfg(GLOBAL_OFFSET, 32'(u << 4) | 32'h0000_000c);
			drv(2'h0, 1'b0, 1'b0);
			hi = 1'b0;
			repeat (8) @(posedge aclk) hi |= clk_out;
			cmp(32'({hi, dres}), 32'(2 * u + 1));
		end
		for (int b = 0; b < 8; b++) begin
			cfg(GLOBAL_OFFSET, 32'(b << 9) | 32'(b & 1));
			cmp(32'({skip, bw}), 32'({1'(b), 8'h01 << b}));
		end
	endtask : t_outputs
	task automatic t_divider();
		for (int k = 0; k < 3; k++) begin
			cfg(GLOBAL_OFFSET, 32'(k << 2));
			count_toggles(1'b0);
			cmp(32'(n), 32'(4 << k));
		end
	endtask : t_divider
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_static();
		t_hybrid();
		t_aux();
		t_outputs();
		t_divider();
		test_done();
	end
endmodule : clock_synth_config_decode_tb
